// *** common/dio_relay_pkg.sv ***
// constants, types and state records of the pin, relay and command block
package dio_relay_pkg;

  localparam int WORD_W = 24;
  localparam int DIO_N = 9;
  localparam int DELAY_W = 16;
  localparam int MP_N = 4;
  localparam int CAL_CH_N = 5;
  localparam int WEIGHT_N = 10;

  // word addresses
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_MASK_BASE = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h1A;
  localparam logic [7:0] ADDR_STATUS_SET = 8'h1B;
  localparam logic [7:0] ADDR_STATUS_CLR = 8'h1C;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h1D;
  localparam logic [7:0] ADDR_CONTROL = 8'h24;
  localparam logic [7:0] ADDR_CONFIG = 8'h25;
  localparam logic [7:0] ADDR_PIN_DIR = 8'h40;
  localparam logic [7:0] ADDR_PIN_POL = 8'h41;
  localparam logic [7:0] ADDR_DELAY_BASE = 8'h42;

  // status bit positions
  localparam int ST_RELAY_1 = 2;
  localparam int ST_RELAY_2 = 1;
  localparam int ST_RESET = 0;

  // command decode
  localparam logic [7:0] CMD_GENERAL = 8'h00;
  localparam logic [7:0] CMD_CAL = 8'hCA;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hBD;
  localparam logic [11:0] CMD_FLASH = 12'hACC;
  localparam logic [3:0] FLASH_SAVE = 4'h2;
  localparam logic [3:0] FLASH_ERASE_0 = 4'h0;
  localparam logic [3:0] FLASH_ERASE_1 = 4'h1;
  localparam int CMD_LL_BIT = 5;
  localparam int CMD_TC_BIT = 4;
  localparam int CAL_CH_LSB = 10;
  localparam int CAL_OFFSET_BIT = 9;

  // control and config fields
  localparam int CTRL_CLR_ACCUM_BIT = 2;
  localparam int CTRL_CLR_ENERGY_BIT = 1;
  localparam int CTRL_MINMAX_BIT = 0;
  localparam int CFG_REF_LSB = 22;

  // strap and multipurpose pin positions
  localparam int PIN_INTERFACE_STRAP_1 = 0;
  localparam int PIN_ADDRESS_STRAP_0 = 1;
  localparam int PIN_ADDRESS_STRAP_1 = 6;
  localparam int PIN_INTERFACE_STRAP_0 = 8;
  localparam int MP_POS [0:MP_N-1] = '{0, 4, 6, 7};

  // reset values
  localparam logic [DIO_N-1:0] DIR_RESET = 9'h1FF;
  localparam logic [DIO_N-1:0] POL_RESET = 9'h000;
  localparam logic [WORD_W-1:0] MASK_RESET = 24'h000000;
  localparam logic [WORD_W-1:0] CONFIG_RESET = 24'h000000;

  typedef enum logic [1:0] {
    HOST_SPI = 2'b00,
    HOST_I2C = 2'b01,
    HOST_UART = 2'b10
  } host_mode_t;

  typedef enum logic [1:0] {
    RLY_IDLE = 2'b00,
    RLY_WAIT_ON = 2'b01,
    RLY_WAIT_OFF = 2'b10
  } relay_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [WORD_W-1:0] data;
  } reg_req_t;

  typedef struct packed {
    logic save;
    logic erase;
    logic section;
  } flash_req_t;

  typedef struct packed {
    logic clrAccum;
    logic clrEnergy;
    logic minMax;
  } control_pulse_t;

  typedef logic [WEIGHT_N-1:0][2:0] weight_set_t;

  typedef struct packed {
    relay_state_t st;
    logic [DELAY_W-1:0] count;
    logic on;
  } relay_timer_t;

  typedef struct packed {
    logic [WORD_W-1:0] command;
    logic [MP_N-1:0][WORD_W-1:0] mask;
    logic [WORD_W-1:0] status;
    logic [DIO_N-1:0] dir;
    logic [DIO_N-1:0] pol;
    logic [DIO_N-1:0] level;
    logic [DIO_N-1:0] out;
    logic [DIO_N-1:0] oe;
    logic [3:0][DELAY_W-1:0] delay;
    logic [WORD_W-1:0] cfg;
    weight_set_t weights;
    logic [WORD_W-1:0] rdData;
    logic prevSign;
    logic strapsTaken;
    host_mode_t hostMode;
    logic [1:0] devAddr;
    logic lineLock;
    logic tempComp;
    logic calStart;
    flash_req_t flashReq;
    control_pulse_t ctrl;
    logic [1:0] erased;
    logic builtinDefaults;
    logic softRst;
  } top_state_t;

endpackage : dio_relay_pkg

// *** hw/relay_delay_timer.sv ***
// zero-crossing referenced on/off delay for one relay output
`timescale 1ns/10ps
`default_nettype none
module relay_delay_timer
  import dio_relay_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sampleTick,
  input wire logic zcRise,
  input wire logic zcFall,
  input wire logic want,
  input wire logic [DELAY_W-1:0] onDelay,
  input wire logic [DELAY_W-1:0] offDelay,
  output var logic relayOn
);

  relay_timer_t s;
  relay_timer_t n;

  always_comb begin
    n = s;
    unique case (s.st)
      RLY_IDLE: begin
        if (want && !s.on && zcRise) begin
          n.st = RLY_WAIT_ON;
          n.count = onDelay;
        end else if (!want && s.on && zcFall) begin
          n.st = RLY_WAIT_OFF;
          n.count = offDelay;
        end
      end
      RLY_WAIT_ON: begin
        // count zero still costs one tick: the pipeline sample
        if (sampleTick) begin
          if (s.count == '0) begin
            n.on = 1'b1;
            n.st = RLY_IDLE;
          end else begin
            n.count = s.count - 1'b1;
          end
        end
      end
      RLY_WAIT_OFF: begin
        if (sampleTick) begin
          if (s.count == '0) begin
            n.on = 1'b0;
            n.st = RLY_IDLE;
          end else begin
            n.count = s.count - 1'b1;
          end
        end
      end
      default: begin
        n.st = RLY_IDLE;
      end
    endcase
    if (rst) begin
      n = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s <= n;
  end

  assign relayOn = s.on;

endmodule : relay_delay_timer
`default_nettype wire

// *** hw/mask_match.sv ***
// status and mask match for one multipurpose pin
`timescale 1ns/10ps
`default_nettype none
module mask_match
  import dio_relay_pkg::*;
(
  input wire logic [WORD_W-1:0] status,
  input wire logic [WORD_W-1:0] mask,
  input wire logic relayA,
  input wire logic relayB,
  output logic active
);

  always_comb begin
    // relay 1 in the mask hides every other masked bit, relay 2 every bit but relay 1
    if (mask[ST_RELAY_1]) begin
      active = relayA;
    end else if (mask[ST_RELAY_2]) begin
      active = relayB;
    end else begin
      active = |(status & mask);
    end
  end

endmodule : mask_match
`default_nettype wire

// *** hw/dio_relay_command_control.sv ***
// pin word, multipurpose pins, relay timing and command decode
`timescale 1ns/10ps
`default_nettype none
module dio_relay_command_control
  import dio_relay_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire reg_req_t regReq,
  output logic [WORD_W-1:0] rdData,
  input wire logic [DIO_N-1:0] pinIn,
  input wire logic [DIO_N-1:0] padDriven,
  output logic [DIO_N-1:0] pinOut,
  output logic [DIO_N-1:0] pinOe,
  input wire logic sampleTick,
  input wire logic [3:0] refSign,
  input wire logic [WORD_W-1:0] statusEvent,
  input wire logic calDone,
  input wire logic [CAL_CH_N-1:0] calFailMask,
  input wire logic flashDone,
  output host_mode_t hostMode,
  output logic [1:0] devAddr,
  output logic lineLock,
  output logic tempComp,
  output logic calStart,
  output flash_req_t flashReq,
  output control_pulse_t ctrlPulse,
  output logic builtinDefaults,
  output logic [1:0] refSelect,
  output weight_set_t weights,
  output logic [1:0] relayState
);

  top_state_t s;
  top_state_t n;
  logic localRst;
  logic selSign;
  logic zcRise;
  logic zcFall;
  logic relayA;
  logic relayB;
  logic [MP_N-1:0] mpActive;

  function automatic logic [2:0] decodeWeight(input logic [1:0] bits);
    decodeWeight = 3'({1'b0, bits} - 3'h1);
  endfunction : decodeWeight

  function automatic logic isWrite(input reg_req_t r, input logic [7:0] a);
    isWrite = r.wr && (r.addr == a);
  endfunction : isWrite

  //////////////////////////////////////////////////////////////////////////
  // zero crossing of the selected reference and the relay timers

  assign localRst = rst || s.softRst;
  assign selSign = refSign[s.cfg[CFG_REF_LSB +: 2]];
  assign zcRise = sampleTick && selSign && !s.prevSign;
  assign zcFall = sampleTick && !selSign && s.prevSign;

  relay_delay_timer u_relay_a (
    .core_clk(core_clk),
    .rst(localRst),
    .sampleTick(sampleTick),
    .zcRise(zcRise),
    .zcFall(zcFall),
    .want(s.status[ST_RELAY_1]),
    .onDelay(s.delay[0]),
    .offDelay(s.delay[2]),
    .relayOn(relayA)
  );

  relay_delay_timer u_relay_b (
    .core_clk(core_clk),
    .rst(localRst),
    .sampleTick(sampleTick),
    .zcRise(zcRise),
    .zcFall(zcFall),
    .want(s.status[ST_RELAY_2]),
    .onDelay(s.delay[1]),
    .offDelay(s.delay[3]),
    .relayOn(relayB)
  );

  genvar g;
  generate
    for (g = 0; g < MP_N; g++) begin : g_mp
      mask_match u_match (
        .status(s.status),
        .mask(s.mask[g]),
        .relayA(relayA),
        .relayB(relayB),
        .active(mpActive[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [WORD_W-1:0] setBits;
    logic [WORD_W-1:0] clrBits;
    logic [WORD_W-1:0] others;
    logic [DIO_N-1:0] mpUsed;
    logic [DIO_N-1:0] mpOn;
    logic [DIO_N-1:0] pinRead;
    logic [WORD_W-1:0] rd;
    setBits = '0;
    clrBits = '0;
    others = '0;
    mpUsed = '0;
    mpOn = '0;
    pinRead = '0;
    rd = '0;
    n = s;
    n.calStart = 1'b0;
    n.flashReq = '0;
    n.ctrl = '0;
    n.softRst = 1'b0;

    if (sampleTick) begin
      n.prevSign = selSign;
    end

    // straps are read while every pin is still an input
    if (!s.strapsTaken) begin
      n.strapsTaken = 1'b1;
      if (!pinIn[PIN_INTERFACE_STRAP_0]) begin
        n.hostMode = HOST_SPI;
      end else if (pinIn[PIN_INTERFACE_STRAP_1]) begin
        n.hostMode = HOST_I2C;
      end else begin
        n.hostMode = HOST_UART;
      end
      n.devAddr = {pinIn[PIN_ADDRESS_STRAP_1], pinIn[PIN_ADDRESS_STRAP_0]};
    end

    // status: hardware events, force words and autonomous relay set
    setBits = statusEvent;
    if (isWrite(regReq, ADDR_STATUS_SET)) begin
      setBits = setBits | regReq.data;
    end
    if (isWrite(regReq, ADDR_STATUS_CLR)) begin
      clrBits = regReq.data;
    end
    for (int k = 0; k < MP_N; k++) begin
      others = s.mask[k];
      others[ST_RELAY_1] = 1'b0;
      others[ST_RELAY_2] = 1'b0;
      if (|(s.status & others)) begin
        setBits[ST_RELAY_1] = setBits[ST_RELAY_1] | s.mask[k][ST_RELAY_1];
        setBits[ST_RELAY_2] = setBits[ST_RELAY_2] | s.mask[k][ST_RELAY_2];
      end
    end
    // set wins over a clear landing in the same cycle
    n.status = (s.status & ~clrBits) | setBits;

    // completion reports from the measurement engine
    if (calDone) begin
      n.command[23:16] = 8'h00;
      if (!s.command[CAL_OFFSET_BIT]) begin
        n.command[CAL_CH_LSB +: CAL_CH_N] =
          s.command[CAL_CH_LSB +: CAL_CH_N] & calFailMask;
      end
    end
    if (flashDone) begin
      n.command[23:12] = 12'h000;
    end

    // register writes
    if (isWrite(regReq, ADDR_COMMAND)) begin
      n.command = regReq.data;
      if (regReq.data[23:16] == CMD_SOFT_RESET) begin
        n.softRst = 1'b1;
      end else if (regReq.data[23:16] == CMD_CAL) begin
        n.calStart = 1'b1;
        n.lineLock = regReq.data[CMD_LL_BIT];
      end else if (regReq.data[23:12] == CMD_FLASH) begin
        n.lineLock = regReq.data[CMD_LL_BIT];
        n.tempComp = regReq.data[CMD_TC_BIT];
        if (regReq.data[11:8] == FLASH_SAVE) begin
          n.flashReq.save = 1'b1;
          n.erased = 2'b00;
        end else if (regReq.data[11:8] == FLASH_ERASE_0 ||
                     regReq.data[11:8] == FLASH_ERASE_1) begin
          n.flashReq.erase = 1'b1;
          n.flashReq.section = regReq.data[8];
          n.erased[regReq.data[8]] = 1'b1;
        end
      end else if (regReq.data[23:16] == CMD_GENERAL) begin
        n.lineLock = regReq.data[CMD_LL_BIT];
        n.tempComp = regReq.data[CMD_TC_BIT];
      end
    end
    n.builtinDefaults = &n.erased;

    for (int k = 0; k < MP_N; k++) begin
      if (isWrite(regReq, 8'(ADDR_MASK_BASE + k))) begin
        n.mask[k] = regReq.data;
      end
      if (isWrite(regReq, 8'(ADDR_DELAY_BASE + k))) begin
        n.delay[k] = regReq.data[DELAY_W-1:0];
      end
    end
    if (isWrite(regReq, ADDR_PIN_LEVEL)) begin
      n.level = regReq.data[DIO_N-1:0];
    end
    if (isWrite(regReq, ADDR_PIN_DIR)) begin
      n.dir = regReq.data[DIO_N-1:0];
    end
    if (isWrite(regReq, ADDR_PIN_POL)) begin
      n.pol = regReq.data[DIO_N-1:0];
    end
    if (isWrite(regReq, ADDR_CONTROL)) begin
      n.ctrl.clrAccum = regReq.data[CTRL_CLR_ACCUM_BIT];
      n.ctrl.clrEnergy = regReq.data[CTRL_CLR_ENERGY_BIT];
      n.ctrl.minMax = regReq.data[CTRL_MINMAX_BIT];
    end
    if (isWrite(regReq, ADDR_CONFIG)) begin
      n.cfg = regReq.data;
      for (int f = 0; f < WEIGHT_N; f++) begin
        n.weights[f] = decodeWeight(regReq.data[2*f +: 2]);
      end
    end

    // pin drive; mask logic only reaches a pin the host made an output
    for (int k = 0; k < MP_N; k++) begin
      mpUsed[MP_POS[k]] = |s.mask[k];
      mpOn[MP_POS[k]] = mpActive[k];
    end
    for (int i = 0; i < DIO_N; i++) begin
      if (mpUsed[i]) begin
        n.out[i] = mpOn[i] ? s.pol[i] : !s.pol[i];
      end else begin
        n.out[i] = s.level[i] ^ s.pol[i];
      end
    end
    n.oe = ~s.dir;

    // read side
    for (int i = 0; i < DIO_N; i++) begin
      if (s.oe[i]) begin
        pinRead[i] = s.out[i];
      end else begin
        pinRead[i] = padDriven[i] ? pinIn[i] : 1'b1;
      end
    end
    if (regReq.rd) begin
      rd = '0;
      if (regReq.addr == ADDR_COMMAND) begin
        rd = s.command;
      end else if (regReq.addr == ADDR_STATUS) begin
        rd = s.status;
      end else if (regReq.addr == ADDR_PIN_LEVEL) begin
        rd = WORD_W'(pinRead);
      end else if (regReq.addr == ADDR_CONFIG) begin
        rd = s.cfg;
      end else if (regReq.addr == ADDR_PIN_DIR) begin
        rd = WORD_W'(s.dir);
      end else if (regReq.addr == ADDR_PIN_POL) begin
        rd = WORD_W'(s.pol);
      end
      for (int k = 0; k < MP_N; k++) begin
        if (regReq.addr == 8'(ADDR_MASK_BASE + k)) begin
          rd = s.mask[k];
        end
        if (regReq.addr == 8'(ADDR_DELAY_BASE + k)) begin
          rd = WORD_W'(s.delay[k]);
        end
      end
      n.rdData = rd;
    end

    // hardware or command reset; pins float as inputs
    if (localRst) begin
      n = '0;
      n.dir = DIR_RESET;
      n.oe = '0;
      n.pol = POL_RESET;
      n.cfg = CONFIG_RESET;
      n.status[ST_RESET] = 1'b1;
      for (int k = 0; k < MP_N; k++) begin
        n.mask[k] = MASK_RESET;
      end
      for (int f = 0; f < WEIGHT_N; f++) begin
        n.weights[f] = decodeWeight(CONFIG_RESET[2*f +: 2]);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    s <= n;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdData = s.rdData;
  assign pinOut = s.out;
  assign pinOe = s.oe;
  assign hostMode = s.hostMode;
  assign devAddr = s.devAddr;
  assign lineLock = s.lineLock;
  assign tempComp = s.tempComp;
  assign calStart = s.calStart;
  assign flashReq = s.flashReq;
  assign ctrlPulse = s.ctrl;
  assign builtinDefaults = s.builtinDefaults;
  assign refSelect = s.cfg[CFG_REF_LSB +: 2];
  assign weights = s.weights;
  assign relayState = {relayA, relayB};

endmodule : dio_relay_command_control
`default_nettype wire

// *** tb/dio_relay_sva.sv ***
// concurrent checks on the pin, command and config ports
`timescale 1ns/10ps
`default_nettype none
module dio_relay_sva
  import dio_relay_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire reg_req_t regReq,
  input wire logic [DIO_N-1:0] pinIn,
  input wire logic [DIO_N-1:0] pinOe,
  input wire host_mode_t hostMode,
  input wire logic calStart,
  input wire flash_req_t flashReq,
  input wire control_pulse_t ctrlPulse,
  input wire logic [1:0] refSelect,
  input wire weight_set_t weights
);
  default clocking cb @(posedge core_clk); endclocking
  logic flashHit;
  logic cfgWr;
  assign flashHit = regReq.wr && regReq.addr == ADDR_COMMAND &&
    regReq.data[23:12] == CMD_FLASH;
  assign cfgWr = regReq.wr && regReq.addr == ADDR_CONFIG;
  ////////////////////////////////////////
  function automatic host_mode_t strapMode(logic [DIO_N-1:0] p);
    if (!p[PIN_INTERFACE_STRAP_0])
      return HOST_SPI;
    return p[PIN_INTERFACE_STRAP_1] ? HOST_I2C : HOST_UART;
  endfunction : strapMode
  sequence cmdWr(logic [7:0] op);
    regReq.wr && regReq.addr == ADDR_COMMAND && regReq.data[23:16] == op;
  endsequence
  property dirOe;
    logic [DIO_N-1:0] d;
    disable iff (rst) (regReq.wr && regReq.addr == ADDR_PIN_DIR,
      d = regReq.data[DIO_N-1:0]) |-> ##2 pinOe == ~d;
  endproperty
  property strapTake;
    logic [DIO_N-1:0] p;
    disable iff (rst) ($fell(rst), p = pinIn) |=> hostMode == strapMode(p);
  endproperty
  property refTake;
    logic [1:0] r;
    disable iff (rst) (cfgWr, r = regReq.data[23:22]) |-> ##2 refSelect == r;
  endproperty
  property weightMap;
    logic [1:0] w;
    disable iff (rst) (cfgWr, w = regReq.data[7:6])
      |-> ##2 weights[3] == {1'b0, w} - 3'h1;
  endproperty
  ////////////////////////////////////////
  // reset check has no disable: it must hold while reset is up
  oe_reset_a: assert property (rst |=> pinOe == '0)
    else $error("pin enables not cleared by reset");
  dir_oe_a: assert property (dirOe)
    else $error("pin enable does not follow direction");
  strap_mode_a: assert property (strapTake)
    else $error("host mode not taken from straps");
  cal_start_a: assert property (disable iff (rst)
    cmdWr(CMD_CAL) |=> calStart ##1 !calStart)
    else $error("calibration start pulse wrong");
  soft_reset_a: assert property (disable iff (rst)
    cmdWr(CMD_SOFT_RESET) |-> ##[1:3] pinOe == '0)
    else $error("soft reset left pins driven");
  ctrl_pulse_a: assert property (disable iff (rst)
    regReq.wr && regReq.addr == ADDR_CONTROL
      |=> ctrlPulse == $past(regReq.data[2:0]))
    else $error("control pulses wrong");
  flash_save_a: assert property (disable iff (rst)
    flashHit && regReq.data[11:8] == FLASH_SAVE |=> flashReq == 3'h4)
    else $error("flash save request wrong");
  flash_erase_a: assert property (disable iff (rst)
    flashHit && regReq.data[11:9] == 3'h0
      |=> flashReq.erase && flashReq.section == $past(regReq.data[8]))
    else $error("flash erase request wrong");
  ref_select_a: assert property (refTake)
    else $error("reference select wrong");
  weight_map_a: assert property (weightMap)
    else $error("weight mapping wrong");
endmodule : dio_relay_sva

bind dio_relay_command_control dio_relay_sva chk (
  .core_clk(core_clk), .rst(rst), .regReq(regReq), .pinIn(pinIn),
  .pinOe(pinOe), .hostMode(hostMode), .calStart(calStart),
  .flashReq(flashReq), .ctrlPulse(ctrlPulse), .refSelect(refSelect),
  .weights(weights));
`default_nettype wire

// *** tb/host_model.sv ***
// host side: word writes and reads on the register port
`timescale 1ns/10ps
`default_nettype none
module host_model
  import dio_relay_pkg::*;
(
  input wire logic core_clk,
  output var reg_req_t regReq,
  input wire logic [WORD_W-1:0] rdData
);
  initial regReq = '0;
  // released fields show inverted values so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [WORD_W-1:0] d);
    @(posedge core_clk);
    regReq <= '{addr: a, wr: 1'b1, rd: 1'b0, data: d};
    @(posedge core_clk);
    regReq <= '{addr: ~a, wr: 1'b0, rd: 1'b0, data: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [WORD_W-1:0] q);
    @(posedge core_clk);
    regReq <= '{addr: a, wr: 1'b0, rd: 1'b1, data: '0};
    @(posedge core_clk);
    regReq <= '{addr: ~a, wr: 1'b0, rd: 1'b0, data: '1};
    @(posedge core_clk);
    #1 q = rdData;
  endtask : rd
endmodule : host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// testbench for the pin, relay and command block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import dio_relay_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, sampleTick = 1'b0;
  logic calDone = 1'b0, flashDone = 1'b0;
  logic [DIO_N-1:0] extLevel = 9'h141, padDriven = 9'h1C1;
  logic [DIO_N-1:0] pinIn, pinOut, pinOe;
  logic [3:0] refSign = 4'h0;
  logic [WORD_W-1:0] statusEvent = '0, rdData, q;
  logic [CAL_CH_N-1:0] calFailMask = '0;
  reg_req_t regReq;
  host_mode_t hostMode;
  logic [1:0] devAddr, refSelect, relayState;
  logic lineLock, tempComp, calStart, builtinDefaults;
  flash_req_t flashReq;
  control_pulse_t ctrlPulse;
  weight_set_t weights;
  int err_count = 0, n_checks = 0, cycles = 0;
  // wire level: device drive, else outside drive, else pull-up
  assign pinIn = (pinOe & pinOut) | (~pinOe & padDriven & extLevel) |
    (~pinOe & ~padDriven);
  host_model host (.core_clk(core_clk), .regReq(regReq), .rdData(rdData));
  dio_relay_command_control uut (.core_clk(core_clk), .rst(rst),
    .regReq(regReq), .rdData(rdData), .pinIn(pinIn),
    .padDriven(padDriven), .pinOut(pinOut), .pinOe(pinOe),
    .sampleTick(sampleTick), .refSign(refSign), .statusEvent(statusEvent),
    .calDone(calDone), .calFailMask(calFailMask), .flashDone(flashDone),
    .hostMode(hostMode), .devAddr(devAddr), .lineLock(lineLock),
    .tempComp(tempComp), .calStart(calStart), .flashReq(flashReq),
    .ctrlPulse(ctrlPulse), .builtinDefaults(builtinDefaults),
    .refSelect(refSelect), .weights(weights), .relayState(relayState));
  ////////////////////////////////////////
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [WORD_W-1:0] e,
    input logic [WORD_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [WORD_W-1:0] e,
    input string n);
    host.rd(a, q);
    chk(n, e, q);
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic tick(input logic s);
    @(posedge core_clk);
    refSign <= {3'h0, s};
    sampleTick <= 1'b1;
    @(posedge core_clk);
    sampleTick <= 1'b0;
    cyc(2);
  endtask : tick
  task automatic done(input logic isCal, input logic [4:0] m);
    @(posedge core_clk);
    calDone <= isCal;
    flashDone <= !isCal;
    calFailMask <= m;
    @(posedge core_clk);
    calDone <= 1'b0;
    flashDone <= 1'b0;
    cyc(1);
  endtask : done
  ////////////////////////////////////////
  task automatic t_reset;
    cyc(2);
    chk("pinOe", '0, 24'(pinOe));
    chk("hostMode", 24'(HOST_I2C), 24'(hostMode));
    chk("devAddr", 24'h3, 24'(devAddr));
    rdc(ADDR_STATUS, 24'h1, "status");
    rdc(ADDR_PIN_LEVEL, 24'h17F, "level");
    rdc(8'h30, '0, "unmapped");
    $display("test reset done");
  endtask : t_reset
  task automatic t_dio;
    host.wr(ADDR_PIN_POL, 24'h00F);
    host.wr(ADDR_PIN_LEVEL, 24'h0A5);
    host.wr(ADDR_PIN_DIR, 24'h0E0);
    cyc(2);
    chk("pinOe", 24'h11F, 24'(pinOe));
    chk("pinOut", 24'h00A, 24'(pinOut & pinOe));
    rdc(ADDR_PIN_LEVEL, 24'h06A, "level");
    $display("test dio done");
  endtask : t_dio
  task automatic t_mask;
    host.wr(ADDR_MASK_BASE + 8'h1, 24'h000020);
    cyc(2);
    chk("pin b idle", 24'h1, 24'(pinOut[4]));
    host.wr(ADDR_STATUS_SET, 24'h000020);
    cyc(2);
    chk("pin b on", 24'h0, 24'(pinOut[4]));
    rdc(ADDR_STATUS_SET, '0, "set word");
    rdc(ADDR_STATUS, 24'h21, "status");
    host.wr(ADDR_STATUS_CLR, 24'h000020);
    cyc(2);
    chk("pin b off", 24'h1, 24'(pinOut[4]));
    $display("test mask done");
  endtask : t_mask
  task automatic t_relay;
    host.wr(ADDR_DELAY_BASE, 24'h2);
    host.wr(ADDR_DELAY_BASE + 8'h2, 24'h1);
    host.wr(ADDR_MASK_BASE, 24'h000204);
    @(posedge core_clk);
    statusEvent <= 24'h000200;
    @(posedge core_clk);
    statusEvent <= '0;
    cyc(3);
    rdc(ADDR_STATUS, 24'h205, "status");
    chk("pin a", 24'h0, 24'(pinOut[0]));
    tick(1'b0);
    tick(1'b1);
    tick(1'b1);
    tick(1'b1);
    chk("relay early", 24'h0, 24'(relayState));
    tick(1'b1);
    chk("relay on", 24'h2, 24'(relayState));
    chk("pin a on", 24'h1, 24'(pinOut[0]));
    // surge first: a clear that meets the surge-driven set loses
    host.wr(ADDR_STATUS_CLR, 24'h000200);
    host.wr(ADDR_STATUS_CLR, 24'h000004);
    tick(1'b0);
    tick(1'b0);
    chk("relay hold", 24'h2, 24'(relayState));
    tick(1'b0);
    chk("relay off", 24'h0, 24'(relayState));
    $display("test relay done");
  endtask : t_relay
  task automatic t_cmd;
    host.wr(ADDR_COMMAND, 24'hCA6420);
    cyc(2);
    chk("lineLock", 24'h1, 24'(lineLock));
    done(1'b1, 5'h08);
    rdc(ADDR_COMMAND, 24'h002020, "gain cal");
    host.wr(ADDR_COMMAND, 24'hCA6620);
    done(1'b1, 5'h00);
    rdc(ADDR_COMMAND, 24'h006620, "offset cal");
    host.wr(ADDR_COMMAND, 24'hACC210);
    cyc(2);
    chk("tempComp", 24'h1, 24'(tempComp));
    done(1'b0, 5'h00);
    rdc(ADDR_COMMAND, 24'h000210, "save");
    host.wr(ADDR_COMMAND, 24'hACC000);
    done(1'b0, 5'h00);
    host.wr(ADDR_COMMAND, 24'hACC100);
    done(1'b0, 5'h00);
    chk("defaults", 24'h1, 24'(builtinDefaults));
    host.wr(ADDR_COMMAND, 24'h000030);
    cyc(2);
    chk("general", 24'h3, 24'({lineLock, tempComp}));
    $display("test command done");
  endtask : t_cmd
  task automatic t_cfg;
    logic [WORD_W-1:0] c;
    logic [2:0] w;
    for (int i = 0; i < 3; i++) begin
      host.wr(ADDR_CONTROL, 24'(1 << i));
    end
    rdc(ADDR_CONTROL, '0, "control");
    for (int r = 0; r < 4; r++) begin
      c = {2'(r), 22'h0000E4};
      host.wr(ADDR_CONFIG, c);
      cyc(2);
      chk("refSelect", 24'(r), 24'(refSelect));
    end
    for (int f = 0; f < WEIGHT_N; f++) begin
      // fields of 0xE4 are 00, 01, 10, 11, the rest 00
      w = f == 1 ? 3'h0 : f == 2 ? 3'h1 : f == 3 ? 3'h2 : 3'h7;
      chk("weight", 24'(w), 24'(weights[f]));
    end
    rdc(ADDR_CONFIG, c, "config");
    $display("test config done");
  endtask : t_cfg
  task automatic t_soft;
    @(posedge core_clk);
    extLevel <= 9'h041;
    host.wr(ADDR_COMMAND, 24'hBD0000);
    cyc(4);
    chk("pinOe", '0, 24'(pinOe));
    chk("hostMode", 24'(HOST_SPI), 24'(hostMode));
    chk("defaults", '0, 24'(builtinDefaults));
    rdc(ADDR_PIN_POL, '0, "polarity");
    @(posedge core_clk);
    extLevel <= 9'h140;
    host.wr(ADDR_COMMAND, 24'hBD0000);
    cyc(4);
    chk("hostMode", 24'(HOST_UART), 24'(hostMode));
    $display("test soft reset done");
  endtask : t_soft
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_dio();
    t_mask();
    t_relay();
    t_cmd();
    t_cfg();
    t_soft();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
